// *** tlpa_defs.svh ***
`ifndef TLPA_DEFS_SVH
`define TLPA_DEFS_SVH
// ------------------------------------------------------------
// widths and reset values
// ------------------------------------------------------------
`define TLPA_NUM_LINES 16
`define TLPA_PRIO_W 4
`define TLPA_WAY_W 8
`define TLPA_HOLD_W 8
`define TLPA_HOLD_RST 8'h00
`define TLPA_PRIO_RST 4'h0
`define TLPA_TBL_DEPTH 16
`endif

// *** tlpa_pkg.sv ***
package tlpa_pkg;
  `include "tlpa_defs.svh"
  typedef logic [`TLPA_PRIO_W-1:0] tlpa_prio_t;
  typedef logic [`TLPA_NUM_LINES-1:0] tlpa_lines_t;
  typedef struct packed {
    logic valid;
    tlpa_prio_t primary;
    tlpa_prio_t secondary;
    logic [`TLPA_WAY_W-1:0] way;
  } tlpa_grant_t;
  typedef enum logic [2:0] {
    TLPA_IDLE = 3'b001,
    TLPA_LOOK = 3'b010,
    TLPA_HOLD = 3'b100
  } tlpa_state_t;
endpackage : tlpa_pkg

// *** tlpa_way_table.sv ***
`timescale 1ns/1ps
`include "tlpa_defs.svh"
// ------------------------------------------------------------
// way number table, indexed by primary/secondary pair
// ------------------------------------------------------------
module tlpa_way_table
  import tlpa_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [7:0] wr_addr_in,
  input wire logic [`TLPA_WAY_W-1:0] wr_data_in,
  // read port
  input wire logic [7:0] rd_addr_in,
  output logic [`TLPA_WAY_W-1:0] rd_data_out
);
  logic [`TLPA_WAY_W-1:0] mem [0:255];
  logic [`TLPA_WAY_W-1:0] rd_q;

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= mem[rd_addr_in];
    end
  end

  assign rd_data_out = rd_q;
endmodule : tlpa_way_table

// *** tlpa_arbiter.sv ***
`timescale 1ns/1ps
`include "tlpa_defs.svh"
module tlpa_arbiter
  import tlpa_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // primary request lines, one per number
  input wire logic [15:0] req_in,
  // per-line link configuration
  input wire logic [15:0] is_link_in,
  input wire logic [15:0] link_wide_in,
  // secondary request lines, flattened: line n uses bits n*16 +: 16
  input wire logic [255:0] sec_req_in,
  // hold time of the granted transfer, in clock cycles
  input wire logic [`TLPA_HOLD_W-1:0] hold_cycles_in,
  // way number table load
  input wire logic way_wr_in,
  input wire logic [7:0] way_addr_in,
  input wire logic [`TLPA_WAY_W-1:0] way_data_in,
  // grant outputs
  output tlpa_grant_t grant_out,
  output logic [15:0] grant_line_out,
  output logic busy_out
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [4:0] lowest_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : lowest_set

  // secondary lines a link exposes: all sixteen, or only the lower eight
  function automatic logic [15:0] sec_line_mask(input logic wide);
    logic [15:0] m;
    m = wide ? 16'hFFFF : 16'h00FF;
    return m;
  endfunction : sec_line_mask

  // cycles left after the first grant cycle; zero and one both give one cycle
  function automatic logic [`TLPA_HOLD_W-1:0] hold_start(input logic [`TLPA_HOLD_W-1:0] h);
    logic [`TLPA_HOLD_W-1:0] c;
    c = `TLPA_HOLD_RST;
    if (h != `TLPA_HOLD_RST) begin
      c = h - 8'h01;
    end
    return c;
  endfunction : hold_start

  // ------------------------------------------------------------
  // request combining
  // ------------------------------------------------------------
  logic [15:0] prim_req;
  logic [15:0] sec_masked [16];

  always_comb begin
    for (int n = 0; n < 16; n++) begin
      // narrow links only see their first eight secondary lines
      sec_masked[n] = sec_req_in[n*16 +: 16] & sec_line_mask(link_wide_in[n]);
      // any line may be a link; it competes here only through its combined request
      prim_req[n] = is_link_in[n] ? (|sec_masked[n]) : req_in[n];
    end
  end

  // ------------------------------------------------------------
  // winner selection
  // ------------------------------------------------------------
  logic [4:0] win_p;
  logic [4:0] win_s;
  tlpa_prio_t win_sec;

  always_comb begin
    win_p = lowest_set(prim_req);
    win_s = lowest_set(sec_masked[win_p[3:0]]);
    // plain requesters report secondary zero
    win_sec = is_link_in[win_p[3:0]] ? win_s[3:0] : `TLPA_PRIO_RST;
  end

  // ------------------------------------------------------------
  // occupancy counter
  // ------------------------------------------------------------
  logic [`TLPA_HOLD_W-1:0] cnt_q, cnt_d;
  logic cnt_load;
  logic cnt_run;
  logic cnt_done;

  always_comb begin
    cnt_d = cnt_q;
    if (cnt_load) begin
      cnt_d = hold_start(hold_cycles_in);
    end else if (cnt_run && !cnt_done) begin
      cnt_d = cnt_q - 8'h01;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= `TLPA_HOLD_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign cnt_done = (cnt_q == `TLPA_HOLD_RST);

  // ------------------------------------------------------------
  // arbitration state
  // ------------------------------------------------------------
  tlpa_state_t state_q, state_d;
  tlpa_prio_t prim_q, prim_d;
  tlpa_prio_t sec_q, sec_d;
  logic [15:0] line_q, line_d;
  logic valid_q, valid_d;
  logic busy_q, busy_d;
  logic [`TLPA_WAY_W-1:0] way_rd;

  always_comb begin
    state_d = state_q;
    prim_d = prim_q;
    sec_d = sec_q;
    line_d = 16'h0000;
    valid_d = 1'b0;
    busy_d = busy_q;
    cnt_load = 1'b0;
    cnt_run = 1'b0;
    case (state_q)
      TLPA_IDLE: begin
        busy_d = 1'b0;
        if (!win_p[4]) begin
          prim_d = win_p[3:0];
          sec_d = win_sec;
          line_d[win_p[3:0]] = 1'b1;
          busy_d = 1'b1;
          // one cycle for the way table read before the grant shows
          state_d = TLPA_LOOK;
        end
      end
      TLPA_LOOK: begin
        line_d = line_q;
        valid_d = 1'b1;
        cnt_load = 1'b1;
        state_d = TLPA_HOLD;
      end
      TLPA_HOLD: begin
        // later requests wait, even better ones
        line_d = line_q;
        valid_d = 1'b1;
        cnt_run = 1'b1;
        if (cnt_done) begin
          valid_d = 1'b0;
          line_d = 16'h0000;
          busy_d = 1'b0;
          state_d = TLPA_IDLE;
        end
      end
      default: begin
        state_d = TLPA_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= TLPA_IDLE;
      prim_q <= `TLPA_PRIO_RST;
      sec_q <= `TLPA_PRIO_RST;
      line_q <= 16'h0000;
      valid_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      prim_q <= prim_d;
      sec_q <= sec_d;
      line_q <= line_d;
      valid_q <= valid_d;
      busy_q <= busy_d;
    end
  end

  // ------------------------------------------------------------
  // way number lookup
  // ------------------------------------------------------------
  tlpa_way_table u_way (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_en_in(way_wr_in),
    .wr_addr_in(way_addr_in),
    .wr_data_in(way_data_in),
    // addressed with the next pair so the way is ready when the grant shows
    .rd_addr_in({prim_d, sec_d}),
    .rd_data_out(way_rd)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // the way field comes straight from the table's read register
  assign grant_out = '{
    valid: valid_q,
    primary: prim_q,
    secondary: sec_q,
    way: way_rd
  };
  assign grant_line_out = line_q;
  assign busy_out = busy_q;
endmodule : tlpa_arbiter

// *** tlpa_assertions.sv ***
`timescale 1ns/1ps
module tlpa_assertions
  import tlpa_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // request side
  input wire logic [15:0] req_in,
  input wire logic [15:0] is_link_in,
  input wire logic [7:0] hold_cycles_in,
  // grant side
  input wire tlpa_grant_t grant_out,
  input wire logic [15:0] grant_line_out,
  input wire logic busy_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_hold3;
    grant_out.valid [*3] ##1 !grant_out.valid;
  endsequence
  a_line_onehot: assert property ($onehot0(grant_line_out))
    else $error("grant line not one-hot");
  a_line_match: assert property (grant_out.valid |-> grant_line_out[grant_out.primary])
    else $error("grant line differs from primary");
  a_busy_leads: assert property ($rose(busy_out) |=> $rose(grant_out.valid))
    else $error("grant late after busy");
  a_valid_busy: assert property (grant_out.valid |-> busy_out)
    else $error("grant without busy");
  a_no_preempt: assert property (grant_out.valid && $past(grant_out.valid) |-> $stable(grant_out))
    else $error("grant changed during hold");
  a_gap_after: assert property ($fell(grant_out.valid) |-> !busy_out)
    else $error("busy after hold end");
  a_hold_three: assert property ($rose(grant_out.valid) && hold_cycles_in == 8'h03 |-> s_hold3)
    else $error("hold length wrong");
  a_lowest_wins: assert property ($rose(grant_out.valid) && $past(is_link_in, 2) == 16'h0000 |->
      ($past(req_in, 2) & ((16'h0001 << grant_out.primary) - 16'h0001)) == 16'h0000)
    else $error("lower request passed over");
endmodule : tlpa_assertions
bind tlpa_arbiter tlpa_assertions i_chk (.*);

// *** tlpa_requesters.sv ***
`timescale 1ns/1ps
module tlpa_requesters
  import tlpa_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [255:0] post_in,
  input wire tlpa_grant_t grant_in,
  output logic [15:0] req_out,
  output logic [255:0] sec_req_out
);
  logic [255:0] pend_q, pend_d;
  logic seen_q;
  // a request is a level held until its grant shows; released lines fall low
  always_comb begin
    pend_d = pend_q | post_in;
    if (grant_in.valid && !seen_q) begin
      pend_d[{grant_in.primary, grant_in.secondary}] = 1'b0;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_q <= '0;
      seen_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      seen_q <= grant_in.valid;
    end
  end
  assign sec_req_out = pend_q;
  always_comb for (int n = 0; n < 16; n++) req_out[n] = pend_q[n*16];
endmodule : tlpa_requesters

// *** test_two_level_priority_arbiter.sv ***
`timescale 1ns/1ps
module test_two_level_priority_arbiter
  import tlpa_pkg::*;
();
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] req_in, is_link_in = '0, link_wide_in = '0, grant_line_out;
  logic [255:0] sec_req_in, post = '0;
  logic [7:0] hold_cycles_in = 8'h03, way_addr_in = '0, way_data_in = '0;
  logic way_wr_in = 1'b0;
  logic busy_out;
  tlpa_grant_t grant_out;
  int num_errors = 0;
  int n_checks = 0;
  always #20 clk_in = ~clk_in;
  tlpa_arbiter i_dut (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .req_in(req_in),
    .is_link_in(is_link_in),
    .link_wide_in(link_wide_in),
    .sec_req_in(sec_req_in),
    .hold_cycles_in(hold_cycles_in),
    .way_wr_in(way_wr_in),
    .way_addr_in(way_addr_in),
    .way_data_in(way_data_in),
    .grant_out(grant_out),
    .grant_line_out(grant_line_out),
    .busy_out(busy_out)
  );
  tlpa_requesters i_req (.clk_in, .rst_in, .post_in(post), .grant_in(grant_out),
    .req_out(req_in), .sec_req_out(sec_req_in));
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic send(input logic [255:0] v);
    @(posedge clk_in);
    post <= v;
    @(posedge clk_in);
    post <= '0;
  endtask : send
  // ----------------------------------------
  // wait for one grant, then time its hold
  // ----------------------------------------
  task automatic want(input logic [3:0] p, input logic [3:0] s, input int h);
    int k = 0;
    while (grant_out.valid !== 1'b1 && k < 99) begin
      @(negedge clk_in);
      k++;
    end
    if (grant_out.valid !== 1'b1) begin
      num_errors++;
      stop_test();
    end else begin
      check("pri", grant_out.primary, p);
      check("sec", grant_out.secondary, s);
      check("way", grant_out.way, {p, s} ^ 8'h5A);
      check("line", grant_line_out, 16'h0001 << p);
      k = 0;
      while (grant_out.valid === 1'b1 && k < 99) begin
        @(negedge clk_in);
        k++;
      end
      check("hold", k[15:0], h[15:0]);
    end
  endtask : want
  task automatic t_prim();
    send((256'h1 << 80) | (256'h1 << 32));
    want(4'h2, 4'h0, 3);
    want(4'h5, 4'h0, 3);
    $display("t_prim done");
  endtask : t_prim
  task automatic t_link();
    @(posedge clk_in);
    is_link_in <= 16'h000C;
    link_wide_in <= 16'h0004;
    send((256'h1 << 57) | (256'h1 << 48) | (256'h1 << 44) | (256'h1 << 41));
    want(4'h2, 4'h9, 3);
    want(4'h2, 4'hC, 3);
    want(4'h3, 4'h0, 3);
    // a leaking upper line of the narrow link would be holding the highway here
    repeat (2) @(negedge clk_in);
    check("idle", busy_out, 1'b0);
    $display("t_link done");
  endtask : t_link
  task automatic t_nopre();
    @(posedge clk_in);
    is_link_in <= 16'h0000;
    hold_cycles_in <= 8'h00;
    send(256'h1 << 96);
    send(256'h1);
    want(4'h6, 4'h0, 1);
    want(4'h0, 4'h0, 1);
    $display("t_nopre done");
  endtask : t_nopre
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int a = 0; a < 256; a++) begin
      @(posedge clk_in);
      way_wr_in <= 1'b1;
      way_addr_in <= a[7:0];
      way_data_in <= a[7:0] ^ 8'h5A;
    end
    @(posedge clk_in);
    way_wr_in <= 1'b0;
    t_prim();
    t_link();
    t_nopre();
    stop_test();
  end
endmodule : test_two_level_priority_arbiter
